// *** verilog/ardc_pkg.sv ***
`default_nettype none
package ardc_pkg;
    localparam int CMD_BITS = 8;
    localparam int SEL_WIDTH = 3;
    localparam logic [2:0] SEL_OFFSET = 3'h1;
    localparam logic [2:0] SEL_GAIN = 3'h2;
    localparam logic [2:0] SEL_CONFIG = 3'h3;
    localparam logic [2:0] SEL_SETUP = 3'h5;
    localparam logic [2:0] SEL_DATA = 3'h4;
    localparam int POS_CLASS = 7;
    localparam int POS_CHAN_MSB = 6;
    localparam int POS_CHAN_LSB = 4;
    localparam int POS_DIR = 3;
    localparam int CAL_REG_BITS = 24;
    localparam int CONFIG_REG_BITS = 24;
    localparam int DATA_REG_BITS = 24;
    localparam int SETUP_LEVEL_BITS = 24;
    localparam int SETUP_BITS_PER_SETUP = 12;
    localparam int SETUPS_TWO_CHAN = 4;
    localparam int SETUPS_FOUR_CHAN = 8;
    localparam int SETUPS_EIGHT_CHAN = 16;
    localparam int INIT_ONES_BYTES = 15;
    localparam logic [7:0] INIT_FILL_BYTE = 8'hff;
    localparam logic [7:0] INIT_END_BYTE = 8'hfe;
    localparam int DEFAULT_CHANNELS = 8;
    localparam logic [3:0] DEPTH_RESET = 4'h0;
    typedef enum logic [1:0] {
        ARDC_SEL_NONE_T,
        ARDC_SEL_CAL_T,
        ARDC_SEL_CFG_T,
        ARDC_SEL_STK_T
    } ardc_kind_t;
endpackage
`default_nettype wire

// *** verilog/ardc_bit_counter.sv ***
`default_nettype none
// Loadable down counter that flags its last step
module ardc_bit_counter #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic step,
    output logic [WIDTH-1:0] count,
    output logic last
);
    if (WIDTH < 2) begin : g_bad_width
        $error("WIDTH must be at least 2");
    end
    assign last = (count == {{(WIDTH-1){1'b0}}, 1'b1});
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (step && count != '0) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

// *** verilog/ardc_decoder.sv ***
`default_nettype none
// Overview of operation
// - Low bits 001 offset, 010 gain
// - Bits 6..4 pick one of 2, 4 or 8 channels
// - Setup stack access: zero top nibble, 101
// - Bit 3 clear writes, set reads
// - Stack length 48, 96 or 192 bits
// - Config depth field sets levels shifted
// - Reset or init sequence restores command mode
// - Data register read ignores channel bits
module ardc_decoder #(
    parameter int CHANNELS = ardc_pkg::DEFAULT_CHANNELS
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic cs_n_pin,
    input wire logic [3:0] depth_field,
    input wire logic reg_read_bit,
    output logic sdo,
    output logic sdo_oe,
    output logic command_mode,
    output logic reg_access_active,
    output logic reg_write_strobe,
    output logic reg_write_bit,
    output logic reg_read_strobe,
    output logic [1:0] reg_kind,
    output logic [2:0] channel_index,
    output logic reg_is_gain,
    output logic access_is_read,
    output logic data_read_start
);
    localparam int SETUPS = (CHANNELS == 2) ? ardc_pkg::SETUPS_TWO_CHAN :
        (CHANNELS == 4) ? ardc_pkg::SETUPS_FOUR_CHAN : ardc_pkg::SETUPS_EIGHT_CHAN;
    localparam int LEVEL_LIMIT = SETUPS / 2;
    localparam int CW = 9;

    // Only the three stack sizes exist
    if (CHANNELS != 2 && CHANNELS != 4 && CHANNELS != 8) begin : g_bad_channels
        $error("CHANNELS must be 2, 4 or 8");
    end

    typedef enum logic [1:0] {ARDC_ST_CMD, ARDC_ST_SHIFT, ARDC_ST_DATA} ardc_state_t;

    // Two-stage synchronisers for pins
    logic [1:0] sclk_sync;
    logic [1:0] sdi_sync;
    logic [1:0] cs_sync;
    logic sclk_prev;
    ardc_state_t state;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [3:0] ones_count;
    logic [CW-1:0] count;
    logic last;
    logic cnt_load;
    logic [CW-1:0] cnt_value;

    wire rise = sclk_sync[1] && !sclk_prev;
    wire fall = !sclk_sync[1] && sclk_prev;
    wire selected = !cs_sync[1];
    wire sample = selected && rise;
    wire [7:0] next_shreg = {shreg[6:0], sdi_sync[1]};
    wire byte_done = sample && bitcnt == 3'h7;
    // Named steps keep the clocked blocks short
    wire count_step = sample && state != ARDC_ST_CMD;
    wire write_step = sample && state == ARDC_ST_SHIFT && !access_is_read;
    wire read_step = selected && fall && state != ARDC_ST_CMD && access_is_read;

    wire [2:0] sel = next_shreg[2:0];
    wire top_zero = next_shreg[7:4] == 4'h0;
    wire class_reg = !next_shreg[ardc_pkg::POS_CLASS];
    wire is_cal = class_reg && (sel == ardc_pkg::SEL_OFFSET || sel == ardc_pkg::SEL_GAIN);
    wire [2:0] chan = next_shreg[ardc_pkg::POS_CHAN_MSB:ardc_pkg::POS_CHAN_LSB];
    wire chan_ok = 32'(chan) < CHANNELS;
    wire is_cfg = top_zero && sel == ardc_pkg::SEL_CONFIG;
    wire is_stk = top_zero && sel == ardc_pkg::SEL_SETUP;
    wire is_data = class_reg && sel == ardc_pkg::SEL_DATA && next_shreg[ardc_pkg::POS_DIR];
    wire dir_read = next_shreg[ardc_pkg::POS_DIR];

    // Depth field counts levels of two setups, capped at the variant's stack
    wire [4:0] depth_levels = {1'b0, depth_field} + 5'h01;
    wire [4:0] levels = (32'(depth_levels) > LEVEL_LIMIT) ? 5'(LEVEL_LIMIT) : depth_levels;
    wire [CW-1:0] stk_bits = CW'(levels) * CW'(ardc_pkg::SETUP_LEVEL_BITS);
    wire [CW-1:0] access_bits = is_stk ? stk_bits :
        is_cfg ? CW'(ardc_pkg::CONFIG_REG_BITS) : CW'(ardc_pkg::CAL_REG_BITS);
    wire start_access = byte_done && state == ARDC_ST_CMD &&
        ((is_cal && chan_ok) || is_cfg || is_stk);
    wire start_data = byte_done && state == ARDC_ST_CMD && is_data;
    wire init_done = byte_done && ones_count == 4'(ardc_pkg::INIT_ONES_BYTES)
        && next_shreg == ardc_pkg::INIT_END_BYTE;

    assign cnt_load = start_access || start_data;
    assign cnt_value = start_data ? CW'(ardc_pkg::DATA_REG_BITS) : access_bits;

    ardc_bit_counter #(.WIDTH(CW)) u_count (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .load(cnt_load),
        .load_value(cnt_value),
        .step(count_step),
        .count(count),
        .last(last)
    );

    // Reset to idle levels so no false sclk edge follows reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclk_sync <= 2'h3;
            sdi_sync <= 2'h0;
            cs_sync <= 2'h3;
            sclk_prev <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], sclk_pin};
            sdi_sync <= {sdi_sync[0], sdi_pin};
            cs_sync <= {cs_sync[0], cs_n_pin};
            sclk_prev <= sclk_sync[1];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shreg <= 8'h00;
            bitcnt <= 3'h0;
        end else if (sample) begin
            shreg <= next_shreg;
            bitcnt <= bitcnt + 3'h1;
        end
    end

    // Fill bytes counted in any state so the init sequence escapes a stuck access
    always_ff @(posedge mclk) begin
        if (sys_rst || init_done) begin
            ones_count <= 4'h0;
        end else if (byte_done) begin
            if (next_shreg == ardc_pkg::INIT_FILL_BYTE) begin
                if (ones_count != 4'(ardc_pkg::INIT_ONES_BYTES)) begin
                    ones_count <= ones_count + 4'h1;
                end
            end else begin
                ones_count <= 4'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || init_done) begin
            state <= ARDC_ST_CMD;
        end else begin
            case (state)
                ARDC_ST_CMD: begin
                    if (start_access) begin
                        state <= ARDC_ST_SHIFT;
                    end else if (start_data) begin
                        state <= ARDC_ST_DATA;
                    end
                end
                ARDC_ST_SHIFT, ARDC_ST_DATA: begin
                    if (sample && last) begin
                        state <= ARDC_ST_CMD;
                    end
                end
                default: state <= ARDC_ST_CMD;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_kind <= 2'(ardc_pkg::ARDC_SEL_NONE_T);
            channel_index <= 3'h0;
            reg_is_gain <= 1'b0;
            access_is_read <= 1'b0;
        end else if (start_access) begin
            reg_kind <= is_stk ? 2'(ardc_pkg::ARDC_SEL_STK_T) :
                is_cfg ? 2'(ardc_pkg::ARDC_SEL_CFG_T) : 2'(ardc_pkg::ARDC_SEL_CAL_T);
            channel_index <= is_cal ? chan : 3'h0;
            reg_is_gain <= sel == ardc_pkg::SEL_GAIN;
            access_is_read <= dir_read;
        end else if (start_data) begin
            reg_kind <= 2'(ardc_pkg::ARDC_SEL_NONE_T);
            channel_index <= 3'h0;
            access_is_read <= 1'b1;
        end
    end

    // Writes capture one host bit per sclk rise; reads present on the fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_write_strobe <= 1'b0;
            reg_write_bit <= 1'b0;
            reg_read_strobe <= 1'b0;
            sdo <= 1'b0;
        end else begin
            reg_write_strobe <= write_step;
            reg_write_bit <= sdi_sync[1];
            reg_read_strobe <= read_step;
            if (read_step) begin
                sdo <= reg_read_bit;
            end
        end
    end

    // Levels follow the state one cycle late; reg_kind, channel_index and access_is_read change with it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sdo_oe <= 1'b0;
            command_mode <= 1'b1;
            reg_access_active <= 1'b0;
            data_read_start <= 1'b0;
        end else begin
            sdo_oe <= selected && state != ARDC_ST_CMD && access_is_read;
            command_mode <= state == ARDC_ST_CMD;
            reg_access_active <= state == ARDC_ST_SHIFT;
            data_read_start <= start_data;
        end
    end
endmodule
`default_nettype wire

// *** testbench/ardc_decoder_assertions.sv ***
`default_nettype none
module ardc_decoder_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic command_mode,
    input wire logic reg_access_active,
    input wire logic reg_write_strobe,
    input wire logic reg_read_strobe,
    input wire logic [1:0] reg_kind,
    input wire logic [2:0] channel_index,
    input wire logic access_is_read
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_wr_pulse: assert property (reg_write_strobe |=> !reg_write_strobe)
        else $error("long write strobe");
    chk_rd_pulse: assert property (reg_read_strobe |=> !reg_read_strobe)
        else $error("long read strobe");
    chk_rd_dir: assert property (reg_read_strobe |-> access_is_read)
        else $error("read strobe on write");
    chk_wr_dir: assert property (reg_write_strobe |-> !access_is_read)
        else $error("write strobe on read");
    chk_mode_excl: assert property (command_mode |-> !reg_access_active)
        else $error("shift in command mode");
    chk_chan_zero: assert property (reg_access_active && reg_kind != 2'h1
        |-> channel_index == 3'h0)
        else $error("channel on non cal access");
    chk_kind_hold: assert property (reg_access_active && $past(reg_access_active)
        |-> $stable(reg_kind))
        else $error("kind moved in access");
    chk_oe_read: assert property (sdo_oe |-> access_is_read)
        else $error("drive on write");
    chk_wr_active: assert property (reg_write_strobe |-> reg_access_active)
        else $error("write strobe outside access");
    chk_sdo_step: assert property ($changed(sdo) |-> reg_read_strobe)
        else $error("serial out moved without read step");
    chk_oe_mode: assert property (sdo_oe |-> !command_mode)
        else $error("drive in command mode");
endmodule
bind ardc_decoder ardc_decoder_assertions u_chk (.mclk, .sys_rst, .sdo, .sdo_oe, .command_mode,
    .reg_access_active, .reg_write_strobe, .reg_read_strobe, .reg_kind, .channel_index,
    .access_is_read);
`default_nettype wire

// *** testbench/ardc_host_model.sv ***
`default_nettype none
module ardc_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // Clock idles high between frames, MSB first; edges land on mclk falls
    task automatic shift(input logic [7:0] b, input int n);
        @(negedge mclk);
        for (int i = 7; i > 7 - n; i--) begin
            sclk = 1'b0;
            sdi = b[i];
            repeat (4) @(negedge mclk);
            sclk = 1'b1;
            repeat (4) @(negedge mclk);
        end
        sdi = ~sdi; // Released line must not keep its value
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_ardc_decoder.sv ***
`default_nettype none
module tb_ardc_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, sys_rst, sclk, sdi, cs_n_pin, reg_read_bit, command_mode, reg_is_gain;
    logic reg_write_strobe, reg_read_strobe, access_is_read, data_read_start;
    logic [3:0] depth_field;
    logic [1:0] reg_kind;
    logic [2:0] channel_index;
    logic sdo, sdo_oe, reg_access_active, reg_write_bit;
    int fail_count = 0, checks_done = 0, strobes = 0, starts = 0, write_ones = 0;
    ardc_decoder u_ardc_decoder (.mclk, .sys_rst, .sclk_pin(sclk), .sdi_pin(sdi), .cs_n_pin,
        .depth_field, .reg_read_bit, .sdo, .sdo_oe, .command_mode, .reg_access_active,
        .reg_write_strobe, .reg_write_bit, .reg_read_strobe, .reg_kind, .channel_index,
        .reg_is_gain, .access_is_read, .data_read_start);
    ardc_host_model u_ardc_host_model (.mclk, .sclk, .sdi);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        strobes <= strobes + int'(reg_write_strobe | reg_read_strobe);
        starts <= starts + int'(data_read_start);
        write_ones <= write_ones + int'(reg_write_strobe & reg_write_bit);
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_cmd;
        for (int i = 0; i < 20 && command_mode !== 1'b1; i++) @(posedge mclk);
        if (command_mode !== 1'b1) begin
            check("timeout", 8'(command_mode), 8'h1);
            finish_test();
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic access(input logic [7:0] cmd, input int bits, input logic [7:0] kind, ch, g);
        int s0, o0;
        if (cmd[3]) reg_read_bit <= !reg_read_bit;
        u_ardc_host_model.shift(cmd, 8);
        repeat (6) @(posedge mclk);
        s0 = strobes;
        o0 = write_ones;
        check("kind", 8'(reg_kind), kind);
        check("chan", 8'(channel_index), ch);
        check("dir", 8'(access_is_read), 8'(cmd[3]));
        check("oe", 8'(sdo_oe), 8'(cmd[3]));
        check("active", 8'(reg_access_active), 8'h1);
        if (kind == 8'h1)
            check("gain", 8'(reg_is_gain), g);
        for (int i = 0; i < bits; i += 8) u_ardc_host_model.shift(8'ha5, 8);
        wait_cmd();
        check("bits", 8'(strobes - s0), 8'(bits));
        check("ones", 8'(write_ones - o0), cmd[3] ? 8'h00 : 8'(bits / 2));
        if (cmd[3])
            check("sdo", 8'(sdo), 8'(reg_read_bit));
    endtask
    task automatic test_cal;
        for (int c = 0; c < 16; c++)
            access({1'b0, 3'(c >> 1), c[0], 1'b0, c[0], ~c[0]}, 24, 8'h1, 8'(c >> 1), 8'(c[0]));
        $display("cal done");
    endtask
    task automatic test_cfg_stack;
        access(8'h03, 24, 8'h2, 8'h0, 8'h0);
        access(8'h0b, 24, 8'h2, 8'h0, 8'h0);
        depth_field <= 4'h1;
        access(8'h05, 48, 8'h3, 8'h0, 8'h0);
        depth_field <= 4'hf;
        access(8'h0d, 192, 8'h3, 8'h0, 8'h0);
        $display("stack done");
    endtask
    task automatic test_data;
        int s0;
        access(8'h7a, 24, 8'h1, 8'h7, 8'h1);
        s0 = starts;
        u_ardc_host_model.shift(8'h7c, 8);
        repeat (6) @(posedge mclk);
        check("data kind", 8'(reg_kind), 8'h0);
        check("data chan", 8'(channel_index), 8'h0);
        check("data oe", 8'(sdo_oe), 8'h1);
        for (int i = 0; i < 3; i++) u_ardc_host_model.shift(8'h00, 8);
        wait_cmd();
        check("start", 8'(starts - s0), 8'h1);
        $display("data done");
    endtask
    task automatic test_init;
        u_ardc_host_model.shift(8'h0e, 8);
        repeat (6) @(posedge mclk);
        check("refused", 8'(command_mode), 8'h1);
        cs_n_pin <= 1'b1;
        u_ardc_host_model.shift(8'h0a, 8);
        repeat (6) @(posedge mclk);
        check("deselected", 8'(command_mode), 8'h1);
        cs_n_pin <= 1'b0;
        u_ardc_host_model.shift(8'h05, 8);
        u_ardc_host_model.shift(8'h00, 8);
        repeat (6) @(posedge mclk);
        check("stuck mode", 8'(command_mode), 8'h0);
        check("stuck active", 8'(reg_access_active), 8'h1);
        for (int i = 0; i < 15; i++) u_ardc_host_model.shift(8'hff, 8);
        u_ardc_host_model.shift(8'hfe, 8);
        wait_cmd();
        access(8'h0a, 24, 8'h1, 8'h0, 8'h1);
        $display("init done");
    endtask
    task automatic test_reset;
        u_ardc_host_model.shift(8'h05, 8);
        repeat (6) @(posedge mclk);
        check("busy mode", 8'(command_mode), 8'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check("reset mode", 8'(command_mode), 8'h1);
        access(8'h0b, 24, 8'h2, 8'h0, 8'h0);
        $display("reset done");
    endtask
    initial begin
        sys_rst = 1'b1;
        cs_n_pin = 1'b0;
        reg_read_bit = 1'b1;
        depth_field = 4'h0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        test_cal();
        test_cfg_stack();
        test_data();
        test_init();
        test_reset();
        finish_test();
    end
endmodule
`default_nettype wire
